// *** lsu_pkg.sv ***
package lsu_pkg;

  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] LSU_CTRL_OFS   = 8'h00;
  localparam logic [7:0] LSU_STATUS_OFS = 8'h04;
  localparam logic [7:0] LSU_BASE_OFS   = 8'h08;
  localparam logic [7:0] LSU_OFFSET_OFS = 8'h0C;
  localparam logic [7:0] LSU_WDATA_OFS  = 8'h10;
  localparam logic [7:0] LSU_RESULT_OFS = 8'h14;
  localparam logic [7:0] LSU_BRANCH_OFS = 8'h18;
  localparam logic [7:0] LSU_FLAGS_OFS  = 8'h1C;

  // control register layout: start strobe in bit 0, operation fields above it
  localparam int         LSU_CTRL_START_BIT = 0;
  localparam int         LSU_CTRL_FIELD_LSB = 1;
  localparam int         LSU_CTRL_FIELD_W   = 12;
  localparam logic [3:0] LSU_FLAGS_RESET    = 4'h0;

  typedef enum logic [1:0]
  {
    LSU_SIZE_BYTE = 2'h0,
    LSU_SIZE_HALF = 2'h1,
    LSU_SIZE_WORD = 2'h2
  } lsu_size_t;

  typedef enum logic [1:0]
  {
    LSU_MODE_OFFSET = 2'h0,
    LSU_MODE_PRE    = 2'h1,
    LSU_MODE_POST   = 2'h2,
    LSU_MODE_REGOFS = 2'h3
  } lsu_mode_t;

  typedef enum logic [1:0]
  {
    LSU_ST_IDLE   = 2'b01,
    LSU_ST_ACCESS = 2'b10
  } lsu_state_t;

  typedef struct packed
  {
    logic       subtract;
    logic       privileged;
    logic       dest_is_pc;
    logic       unpriv;
    logic [1:0] left_shift;
    lsu_mode_t  mode;
    logic       is_signed;
    lsu_size_t  size;
    logic       is_load;
  } lsu_ctrl_t;

  typedef struct packed
  {
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    lsu_size_t         size;
    logic              write;
    logic              priv;
  } lsu_mem_req_t;

endpackage : lsu_pkg

// *** lsu_core.sv ***
// How it works
// - word load into program counter branches to loaded value with bit 0 cleared
// - loads and stores never change the condition flags
// - register offset address is base plus offset shifted left zero to three
// - size picks width; unsigned zero-extends, signed sign-extends, signed only for loads
// - register offset transfers byte, halfword or word, loads signed or unsigned
// - unprivileged variants access memory with unprivileged rights
// - unprivileged variants in unprivileged software act like ordinary forms
// - pre-index accesses base plus or minus offset, post-index the base; both write back that sum or difference
//
// Chosen here: the APB interface to the registers and the register addresses.
module lsu_core
  import lsu_pkg::*;
#(
  parameter int PADDR_W = 8
)
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0]  pwdata,
  output logic      [DATA_W-1:0]  prdata,
  output logic                    pready,
  output logic                    pslverr,
  output lsu_mem_req_t            mem_req,
  output logic                    mem_valid,
  input  wire logic               mem_ack,
  input  wire logic [DATA_W-1:0]  mem_rdata,
  output logic      [3:0]         cond_flags,
  output logic                    branch_valid,
  output logic      [DATA_W-1:0]  branch_target,
  output logic                    wb_valid,
  output logic      [DATA_W-1:0]  wb_base
);

  if (PADDR_W < 8)
  begin : g_chk
    $error("lsu_core: PADDR_W must be at least 8");
  end

  lsu_state_t        state;
  lsu_ctrl_t         ctrl;
  logic [DATA_W-1:0] base_val;
  logic [DATA_W-1:0] offset_val;
  logic [DATA_W-1:0] store_data;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] wb_sum;
  logic              done;
  logic              branch_taken;
  lsu_ctrl_t         new_ctrl;
  logic [7:0]        reg_addr;
  logic              mapped;
  logic              wr_en;
  logic              start;
  logic [DATA_W-1:0] eff_offset;
  logic [DATA_W-1:0] sum_addr;
  logic [DATA_W-1:0] access_addr;
  logic [DATA_W-1:0] load_ext;
  logic [DATA_W-1:0] rd_mux;
  logic              finish;
  logic              writeback;

  assign reg_addr = paddr[7:0];
  assign mapped   = (paddr[PADDR_W-1:0] >> 5) == '0 && reg_addr[1:0] == 2'h0;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign wr_en    = psel & penable & pwrite & mapped;
  assign start    = wr_en && reg_addr == LSU_CTRL_OFS && pwdata[LSU_CTRL_START_BIT]
                    && state == LSU_ST_IDLE;
  assign finish   = state == LSU_ST_ACCESS && mem_ack;
  assign writeback = ctrl.mode == LSU_MODE_PRE || ctrl.mode == LSU_MODE_POST;
  assign new_ctrl  = lsu_ctrl_t'(pwdata[LSU_CTRL_FIELD_LSB +: LSU_CTRL_FIELD_W]);
  // fields arrive with the start strobe, so decode them straight from the bus
  always_comb
  begin
    if (new_ctrl.mode == LSU_MODE_REGOFS)
      eff_offset = offset_val << new_ctrl.left_shift;
    else
      eff_offset = offset_val;
    if (new_ctrl.subtract && new_ctrl.mode != LSU_MODE_REGOFS)
      sum_addr = base_val - eff_offset;
    else
      sum_addr = base_val + eff_offset;
    if (new_ctrl.mode == LSU_MODE_POST)
      access_addr = base_val;
    else
      access_addr = sum_addr;
  end

  // load data sizing
  always_comb
  begin
    unique case (ctrl.size)
      LSU_SIZE_BYTE:
        load_ext = {{24{ctrl.is_signed & mem_rdata[7]}}, mem_rdata[7:0]};
      LSU_SIZE_HALF:
        load_ext = {{16{ctrl.is_signed & mem_rdata[15]}}, mem_rdata[15:0]};
      default:
        load_ext = mem_rdata;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= LSU_ST_IDLE;
    else if (start)
      state <= LSU_ST_ACCESS;
    else if (finish)
      state <= LSU_ST_IDLE;
  end

  // operand registers frozen while an access is in flight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl       <= '0;
      offset_val <= '0;
      store_data <= '0;
      cond_flags <= LSU_FLAGS_RESET;
    end
    else if (wr_en && state == LSU_ST_IDLE)
    begin
      if (reg_addr == LSU_CTRL_OFS)
        ctrl <= new_ctrl;
      if (reg_addr == LSU_OFFSET_OFS)
        offset_val <= pwdata;
      if (reg_addr == LSU_WDATA_OFS)
        store_data <= pwdata;
      if (reg_addr == LSU_FLAGS_OFS)
        cond_flags <= pwdata[3:0];
    end
  end

  // base register copy, updated by software or by writeback
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      base_val <= '0;
    else if (finish && writeback)
      base_val <= wb_sum;
    else if (wr_en && state == LSU_ST_IDLE && reg_addr == LSU_BASE_OFS)
      base_val <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_valid <= 1'b0;
      mem_req   <= '0;
      wb_sum    <= '0;
    end
    else if (start)
    begin
      mem_valid     <= 1'b1;
      mem_req.addr  <= access_addr;
      mem_req.wdata <= store_data;
      mem_req.size  <= new_ctrl.size;
      mem_req.write <= ~new_ctrl.is_load;
      // privilege drops for unprivileged variants regardless of caller
      mem_req.priv  <= new_ctrl.privileged & ~new_ctrl.unpriv;
      wb_sum        <= sum_addr;
    end
    else if (finish)
      mem_valid <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result        <= '0;
      done          <= 1'b0;
      branch_taken  <= 1'b0;
      branch_valid  <= 1'b0;
      branch_target <= '0;
      wb_valid      <= 1'b0;
      wb_base       <= '0;
    end
    else
    begin
      branch_valid <= 1'b0;
      wb_valid     <= 1'b0;
      if (start)
      begin
        done         <= 1'b0;
        branch_taken <= 1'b0;
      end
      if (finish)
      begin
        done <= 1'b1;
        if (ctrl.is_load)
          result <= load_ext;
        if (ctrl.is_load && ctrl.dest_is_pc && ctrl.size == LSU_SIZE_WORD)
        begin
          // halfword-aligned target; bit 0 of the value is the state bit
          branch_valid  <= 1'b1;
          branch_taken  <= 1'b1;
          branch_target <= {mem_rdata[DATA_W-1:1], 1'b0};
        end
        if (writeback)
        begin
          wb_valid <= 1'b1;
          wb_base  <= wb_sum;
        end
      end
    end
  end

  always_comb
  begin
    rd_mux = '0;
    unique case (reg_addr)
      LSU_CTRL_OFS:   rd_mux[LSU_CTRL_FIELD_LSB +: LSU_CTRL_FIELD_W] = ctrl;
      LSU_STATUS_OFS: rd_mux[2:0] = {branch_taken, done, state == LSU_ST_ACCESS};
      LSU_BASE_OFS:   rd_mux = base_val;
      LSU_OFFSET_OFS: rd_mux = offset_val;
      LSU_WDATA_OFS:  rd_mux = store_data;
      LSU_RESULT_OFS: rd_mux = result;
      LSU_BRANCH_OFS: rd_mux = branch_target;
      LSU_FLAGS_OFS:  rd_mux[3:0] = cond_flags;
      default:        rd_mux = '0;
    endcase
  end

  // read data captured in the setup cycle so prdata comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  sequence s_wait_ack;
    mem_valid && !mem_ack;
  endsequence

  sequence s_access_done;
    state == LSU_ST_ACCESS && mem_ack;
  endsequence

  a_req_held: assert property (@(posedge pclk) disable iff (!presetn)
    s_wait_ack |=> mem_valid && $stable(mem_req))
    else $error("request changed before acknowledge");

  a_branch_even: assert property (@(posedge pclk) disable iff (!presetn)
    s_access_done ##0 (ctrl.is_load && ctrl.dest_is_pc && ctrl.size == LSU_SIZE_WORD)
    |=> branch_valid && branch_target == {$past(mem_rdata[DATA_W-1:1]), 1'b0})
    else $error("branch target wrong");

  a_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state == LSU_ST_ACCESS |=> $stable(cond_flags))
    else $error("flags changed by access");

  a_reg_offset: assert property (@(posedge pclk) disable iff (!presetn)
    start && new_ctrl.mode == LSU_MODE_REGOFS
    |=> mem_req.addr == $past(base_val) + ($past(offset_val) << $past(new_ctrl.left_shift)))
    else $error("register offset address wrong");

  a_sign_byte: assert property (@(posedge pclk) disable iff (!presetn)
    s_access_done ##0 (ctrl.is_load && ctrl.is_signed && ctrl.size == LSU_SIZE_BYTE)
    |=> result == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
    else $error("signed byte not extended");

  a_zero_half: assert property (@(posedge pclk) disable iff (!presetn)
    s_access_done ##0 (ctrl.is_load && !ctrl.is_signed && ctrl.size == LSU_SIZE_HALF)
    |=> result == {16'h0000, $past(mem_rdata[15:0])})
    else $error("unsigned halfword not zero extended");

  a_unpriv_rights: assert property (@(posedge pclk) disable iff (!presetn)
    mem_valid && ctrl.unpriv |-> !mem_req.priv)
    else $error("unprivileged variant used privileged rights");

  a_priv_report: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> mem_req.priv == ($past(new_ctrl.privileged) && !$past(new_ctrl.unpriv)))
    else $error("access privilege misreported");

  a_post_index: assert property (@(posedge pclk) disable iff (!presetn)
    start && new_ctrl.mode == LSU_MODE_POST
    |=> mem_req.addr == $past(base_val) && wb_sum == $past(sum_addr))
    else $error("post index address wrong");

  a_write_back: assert property (@(posedge pclk) disable iff (!presetn)
    s_access_done ##0 writeback |=> wb_valid && base_val == wb_base)
    else $error("writeback missing");

endmodule : lsu_core

// *** lsu_mem_model.sv ***
module lsu_mem_model
  import lsu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  lsu_mem_req_t     mem_req,
  input  wire logic        mem_valid,
  input  wire logic [3:0]  lat,
  input  wire logic [31:0] load_data,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output lsu_mem_req_t     seen_req
);
  logic [3:0] cnt;
  // data lines toggle outside the ack cycle so a late sample cannot pass by luck
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack   <= 1'b0;
      cnt       <= 4'h0;
      mem_rdata <= 32'h0;
      seen_req  <= '0;
    end
    else if (mem_valid && mem_ack)
    begin
      mem_ack   <= 1'b0;
      cnt       <= 4'h0;
      seen_req  <= mem_req;
      mem_rdata <= ~mem_rdata;
    end
    else if (mem_valid && cnt >= lat)
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= load_data;
    end
    else
    begin
      cnt       <= mem_valid ? cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : lsu_mem_model

// *** load_store_address_unit_tb.sv ***
module load_store_address_unit_tb;
  import lsu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, mem_rdata, load_data = 32'h0;
  logic pready, pslverr, mem_valid, mem_ack;
  logic [3:0] lat = 4'h0;
  logic bv, wv;
  logic [3:0] cf;
  logic [31:0] bt, wb;
  lsu_mem_req_t mem_req, seen_req;
  int mismatches = 0, checks = 0, seed = 32'he5cd;
  always #25 pclk = ~pclk;
  lsu_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_valid(mem_valid), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .cond_flags(cf), .branch_valid(bv), .branch_target(bt),
    .wb_valid(wv), .wb_base(wb));
  int n_br = 0, n_wb = 0, n_br0, n_wb0;
  logic [31:0] bt_seen = 32'h0, wb_seen = 32'h0;
  // pulses stand one cycle, so count and latch them at the edge they stand
  always @(posedge pclk)
  begin
    if (bv)
    begin
      n_br <= n_br + 1;
      bt_seen <= bt;
    end
    if (wv)
    begin
      n_wb <= n_wb + 1;
      wb_seen <= wb;
    end
  end
  lsu_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_valid(mem_valid), .lat(lat), .load_data(load_data), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .seen_req(seen_req));
  task finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      finish_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  logic [31:0] q, base, ofs, d, sum, ea, ex_res = 32'h0, ex_br = 32'h0, fl;
  logic e, br;
  lsu_ctrl_t c;
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h20, 0, q, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    apb(0, 8'h02, 0, q, e);
    chk("unaligned err", 1, e);
    for (int i = 0; i < 96; i++)
    begin
      c = '0;
      c.mode = lsu_mode_t'(i % 4);
      c.size = lsu_size_t'((i / 4) % 3);
      c.is_load = (i / 12) % 2;
      c.is_signed = c.is_load & $random(seed);
      c.left_shift = $random(seed);
      c.privileged = $random(seed);
      c.subtract = $random(seed);
      c.unpriv = (i / 24) % 2 && c.mode == LSU_MODE_OFFSET;
      c.dest_is_pc = c.is_load && c.size == LSU_SIZE_WORD && $random(seed);
      base = $random(seed);
      ofs = c.mode == LSU_MODE_REGOFS ? $random(seed) : $random(seed) & 32'hFF;
      if (c.unpriv)
        c.subtract = 1'b0;
      d = $random(seed);
      if (c.dest_is_pc)
        d[0] = 1'b1;
      fl = $random(seed) & 32'hF;
      lat <= $random(seed) & 4'h3;
      load_data <= d;
      apb(1, LSU_FLAGS_OFS, fl, q, e);
      apb(1, LSU_BASE_OFS, base, q, e);
      apb(1, LSU_OFFSET_OFS, ofs, q, e);
      apb(1, LSU_WDATA_OFS, d, q, e);
      n_br0 = n_br;
      n_wb0 = n_wb;
      apb(1, LSU_CTRL_OFS, {19'h0, c, 1'b1}, q, e);
      // a write leaves prdata stale, so the poll must not trust it
      q = 32'h0;
      for (int n = 0; n < 30 && !(q[1] && !q[0]); n++)
        apb(0, LSU_STATUS_OFS, 0, q, e);
      if (!(q[1] && !q[0]))
      begin
        mismatches++;
        finish_test();
      end
      if (c.mode == LSU_MODE_REGOFS)
        sum = base + (ofs << c.left_shift);
      else
        sum = c.subtract ? base - ofs : base + ofs;
      ea = c.mode == LSU_MODE_POST ? base : sum;
      br = c.dest_is_pc;
      if (c.is_load)
        case (c.size)
          LSU_SIZE_BYTE: ex_res = c.is_signed ? {{24{d[7]}}, d[7:0]} : {24'h0, d[7:0]};
          LSU_SIZE_HALF: ex_res = c.is_signed ? {{16{d[15]}}, d[15:0]} : {16'h0, d[15:0]};
          default: ex_res = d;
        endcase
      if (br)
        ex_br = {d[31:1], 1'b0};
      chk("addr", ea, seen_req.addr);
      chk("size", c.size, seen_req.size);
      chk("write", !c.is_load, seen_req.write);
      chk("priv", c.privileged & ~c.unpriv, seen_req.priv);
      if (!c.is_load)
        chk("wdata", d & (c.size == LSU_SIZE_BYTE ? 32'hFF : c.size == LSU_SIZE_HALF
          ? 32'hFFFF : 32'hFFFFFFFF), seen_req.wdata & (c.size == LSU_SIZE_BYTE ? 32'hFF
          : c.size == LSU_SIZE_HALF ? 32'hFFFF : 32'hFFFFFFFF));
      chk("status", {br, 1'b1, 1'b0}, q[2:0]);
      apb(0, LSU_RESULT_OFS, 0, q, e);
      chk("result", ex_res, q);
      apb(0, LSU_BRANCH_OFS, 0, q, e);
      chk("branch", ex_br, q);
      apb(0, LSU_BASE_OFS, 0, q, e);
      chk("base", c.mode inside {LSU_MODE_PRE, LSU_MODE_POST} ? sum : base, q);
      apb(0, LSU_FLAGS_OFS, 0, q, e);
      chk("flags", fl, q);
      chk("flags pin", fl, cf);
      chk("branch pulse", n_br0 + br, n_br);
      chk("branch pin", ex_br, bt_seen);
      chk("wb pulse", n_wb0 + (c.mode inside {LSU_MODE_PRE, LSU_MODE_POST}), n_wb);
      if (c.mode inside {LSU_MODE_PRE, LSU_MODE_POST})
        chk("wb pin", sum, wb_seen);
    end
    $display("test operations done");
    finish_test();
  end
endmodule : load_store_address_unit_tb
